// *** pmt8_pkg.sv ***
package pmt8_pkg;

  // ************************************************************
  // Register word indices; byte address is four times the index.
  // ************************************************************
  localparam logic [13:0] CTRL_IDX = 14'h0FCA;
  localparam logic [13:0] PERIOD_IDX = 14'h0FCB;
  localparam logic [13:0] COUNT_IDX = 14'h0FCC;
  localparam logic [13:0] FLAGS_IDX = 14'h0F9E;
  localparam logic [13:0] ENABLES_IDX = 14'h0F9D;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int PRE_LSB = 0;
  localparam int PRE_MSB = 1;
  localparam int RUN_BIT = 2;
  localparam int POST_LSB = 3;
  localparam int POST_MSB = 6;
  localparam int CTRL_MSB = 7;
  localparam int MATCH_IRQ_BIT = 1;

  // ************************************************************
  // Reset values.
  // ************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;

  // ************************************************************
  // Prescale codes and divider terminal counts.
  // ************************************************************
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [3:0] PRE_LIM1 = 4'h0;
  localparam logic [3:0] PRE_LIM4 = 4'h3;
  localparam logic [3:0] PRE_LIM16 = 4'hF;
  // The instruction clock is the system clock divided by four.
  localparam int INS_DIV = 4;
  localparam logic [3:0] INS_LIM = 4'(INS_DIV - 1);

  // ************************************************************
  // Bus responses.
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pmt8_pkg

// *** pmt8_scaler.sv ***
module pmt8_scaler (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic adv,
  input wire logic [3:0] limit,
  output logic [3:0] cnt,
  output logic wrap
);

  typedef struct packed {
    logic [3:0] cnt;
  } pmt8_scl_st_t;

  pmt8_scl_st_t st_q;
  pmt8_scl_st_t st_d;

  // A wrap is one advance taken while the count sits at the terminal count.
  assign wrap = adv && !clr && (st_q.cnt == limit);
  assign cnt = st_q.cnt;

  // Clear wins over advance; the counter restarts after a wrap.
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.cnt = 4'h0;
    end else if (wrap) begin
      st_d.cnt = 4'h0;
    end else if (adv) begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : pmt8_scaler

// *** pmt8_timer.sv ***
// Functional notes
// - While running, the count steps by one per prescaled tick of the instruction clock (mclk/4), from zero.
// - A 4-bit prescaler divides by 1, 4 or 16 for select codes 00, 01 and 10.
// - The count is compared with the period on every prescaled tick and equality makes the match signal.
// - A match loads zero into the count on the next step and advances the postscaler.
// - Reset clears the count and sets the period to all ones.
// - Count writes, control writes and reset clear the prescaler and postscaler.
// - A control write leaves the count as it was.
// - Control bits 6..3 choose a postscale ratio of the field value plus one.
// - The postscaler sets a sticky match flag at flag bit 1 that software clears.
// - Enable bit 1 lets the latched match flag request an interrupt.
// - The unscaled match is exported as a PWM time base.
// - The timer output is offered as a serial port shift clock.
// - Count and period are readable and writable at any time.
// - Control bit 7 reads zero and ignores writes.
//
// Local design decision: the AXI4-Lite slave port.
module pmt8_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic pwm_time_base,
  output logic spi_shift_clk
);

  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    logic awready;
    logic aw_have;
    logic [13:0] aw_idx;
    logic wready;
    logic w_have;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [7:0] period;
    logic flag;
    logic enable;
    logic match;
    logic spi;
    logic irq;
  } pmt8_state_t;

  pmt8_state_t st_q;
  pmt8_state_t st_d;

  logic ctrl_wr;
  logic cnt_wr;
  logic per_wr;
  logic flag_clr;
  logic en_wr;
  logic scl_clr;
  logic run;
  logic ins_wrap;
  logic pre_wrap;
  logic post_wrap;
  logic ptick;
  logic hit;
  logic [3:0] pre_lim;
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;

  // ************************************************************
  // Dividers.
  // ************************************************************

  // Software writes to count or control restart both scalers.
  assign scl_clr = cnt_wr || ctrl_wr;
  assign run = st_q.ctrl[pmt8_pkg::RUN_BIT];

  // Prescale terminal count; the unused code behaves as divide by sixteen.
  always_comb begin
    unique case (st_q.ctrl[pmt8_pkg::PRE_MSB:pmt8_pkg::PRE_LSB])
      pmt8_pkg::PRE_DIV1: pre_lim = pmt8_pkg::PRE_LIM1;
      pmt8_pkg::PRE_DIV4: pre_lim = pmt8_pkg::PRE_LIM4;
      default: pre_lim = pmt8_pkg::PRE_LIM16;
    endcase
  end

  // Instruction clock enable, free running.
  pmt8_scaler u_ins (
    .mclk(mclk),
    .rst(rst),
    .clr(1'h0),
    .adv(1'h1),
    .limit(pmt8_pkg::INS_LIM),
    .cnt(),
    .wrap(ins_wrap)
  );

  // Prescaler only advances while the timer runs.
  pmt8_scaler u_pre (
    .mclk(mclk),
    .rst(rst),
    .clr(scl_clr),
    .adv(ins_wrap && run),
    .limit(pre_lim),
    .cnt(pre_cnt),
    .wrap(pre_wrap)
  );

  // A prescaled tick, and a tick that finds count equal to period.
  assign ptick = pre_wrap && !scl_clr;
  assign hit = ptick && (st_q.count == st_q.period);

  // Postscaler counts matches up to the selected ratio.
  pmt8_scaler u_post (
    .mclk(mclk),
    .rst(rst),
    .clr(scl_clr),
    .adv(hit),
    .limit(st_q.ctrl[pmt8_pkg::POST_MSB:pmt8_pkg::POST_LSB]),
    .cnt(post_cnt),
    .wrap(post_wrap)
  );

  // ************************************************************
  // Next state.
  // ************************************************************

  // Bus slave, register writes, counting and interrupt state.
  always_comb begin
    logic [31:0] rd;
    logic rd_ok;
    logic [13:0] ridx;
    rd = 32'h0000_0000;
    rd_ok = 1'h1;
    ridx = s_axi_araddr[15:2];
    st_d = st_q;
    ctrl_wr = 1'h0;
    cnt_wr = 1'h0;
    per_wr = 1'h0;
    flag_clr = 1'h0;
    en_wr = 1'h0;

    // Write address and data are taken independently.
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'h1;
      st_d.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'h1;
      st_d.wdata = s_axi_wdata[7:0];
      st_d.wlane0 = s_axi_wstrb[0];
    end

    // Once both halves are held, the write is performed and answered.
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      st_d.aw_have = 1'h0;
      st_d.w_have = 1'h0;
      st_d.bvalid = 1'h1;
      st_d.bresp = pmt8_pkg::RESP_OKAY;
      unique case (st_q.aw_idx)
        pmt8_pkg::CTRL_IDX: ctrl_wr = st_q.wlane0;
        pmt8_pkg::COUNT_IDX: cnt_wr = st_q.wlane0;
        pmt8_pkg::PERIOD_IDX: per_wr = st_q.wlane0;
        pmt8_pkg::FLAGS_IDX: flag_clr = st_q.wlane0 && st_q.wdata[pmt8_pkg::MATCH_IRQ_BIT];
        pmt8_pkg::ENABLES_IDX: en_wr = st_q.wlane0;
        default: st_d.bresp = pmt8_pkg::RESP_SLVERR;
      endcase
    end else if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'h0;
    end
    st_d.awready = !st_d.aw_have;
    st_d.wready = !st_d.w_have;

    // Read mux; unused bits read as zero.
    unique case (ridx)
      pmt8_pkg::CTRL_IDX: rd[7:0] = st_q.ctrl;
      pmt8_pkg::COUNT_IDX: rd[7:0] = st_q.count;
      pmt8_pkg::PERIOD_IDX: rd[7:0] = st_q.period;
      pmt8_pkg::FLAGS_IDX: rd[pmt8_pkg::MATCH_IRQ_BIT] = st_q.flag;
      pmt8_pkg::ENABLES_IDX: rd[pmt8_pkg::MATCH_IRQ_BIT] = st_q.enable;
      default: rd_ok = 1'h0;
    endcase

    // One read at a time; the next address is taken after the answer.
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'h1;
      st_d.rdata = rd;
      st_d.rresp = rd_ok ? pmt8_pkg::RESP_OKAY : pmt8_pkg::RESP_SLVERR;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'h0;
    end
    st_d.arready = !st_d.rvalid;

    // Control write; the top bit is not stored.
    if (ctrl_wr) begin
      st_d.ctrl = {1'h0, st_q.wdata[pmt8_pkg::CTRL_MSB - 1:0]};
    end

    // Count: software write wins, else step or wrap on a tick.
    st_d.match = 1'h0;
    if (cnt_wr) begin
      st_d.count = st_q.wdata;
    end else if (hit) begin
      st_d.count = pmt8_pkg::COUNT_RESET;
      st_d.match = 1'h1;
    end else if (ptick) begin
      st_d.count = st_q.count + 8'h01;
    end

    if (per_wr) begin
      st_d.period = st_q.wdata;
    end

    // Shift clock source toggles once per match.
    if (hit) begin
      st_d.spi = !st_q.spi;
    end

    // Sticky flag; a postscaler event in the clear cycle wins.
    if (flag_clr) begin
      st_d.flag = 1'h0;
    end
    if (post_wrap) begin
      st_d.flag = 1'h1;
    end
    if (en_wr) begin
      st_d.enable = st_q.wdata[pmt8_pkg::MATCH_IRQ_BIT];
    end
    st_d.irq = st_d.flag && st_d.enable;
  end

  // ************************************************************
  // State register.
  // ************************************************************

  // Reset puts the registers at their documented values.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.awready <= 1'h1;
      st_q.wready <= 1'h1;
      st_q.arready <= 1'h1;
      st_q.ctrl <= pmt8_pkg::CTRL_RESET;
      st_q.count <= pmt8_pkg::COUNT_RESET;
      st_q.period <= pmt8_pkg::PERIOD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign irq = st_q.irq;
  assign pwm_time_base = st_q.match;
  assign spi_shift_clk = st_q.spi;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  count_step_a: assert property (
    (ptick && !cnt_wr && st_q.count != st_q.period) |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("count did not step on a tick");

  prescale_tick_a: assert property (
    ptick |-> pre_cnt == pre_lim && run)
    else $error("prescaled tick at wrong prescale count");

  match_pulse_a: assert property (
    (ptick && st_q.count == st_q.period) |=> st_q.match ##1 !st_q.match)
    else $error("match pulse missing or too long");

  match_reload_a: assert property (
    (hit && !cnt_wr) |=> st_q.count == pmt8_pkg::COUNT_RESET)
    else $error("count not zero after match");

  reset_values_a: assert property (
    $past(rst) |-> st_q.count == pmt8_pkg::COUNT_RESET && st_q.period == pmt8_pkg::PERIOD_RESET &&
      st_q.ctrl == pmt8_pkg::CTRL_RESET)
    else $error("wrong register values after reset");

  write_clears_a: assert property (
    (cnt_wr || ctrl_wr) |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared by write");

  ctrl_keeps_a: assert property (
    (ctrl_wr && !cnt_wr) |=> st_q.count == $past(st_q.count))
    else $error("control write changed count");

  ctrl_msb_a: assert property (
    st_q.ctrl[pmt8_pkg::CTRL_MSB] == 1'h0)
    else $error("control bit 7 set");

  flag_set_a: assert property (
    post_wrap |=> st_q.flag ##1 (st_q.flag || $past(flag_clr)))
    else $error("match flag not latched");

  irq_level_a: assert property (
    st_q.irq == (st_q.flag && st_q.enable))
    else $error("interrupt output disagrees with flag and enable");

  off_holds_a: assert property (
    (!run && !cnt_wr && !ctrl_wr) |=> $stable(st_q.count) && !st_q.match && $stable(pre_cnt))
    else $error("timer moved while off");

  // A clear with no event in the same cycle drops the flag and the interrupt.
  flag_clear_a: assert property (
    (flag_clr && !post_wrap) |=> !st_q.flag && !st_q.irq)
    else $error("match flag not cleared");

  // Every match turns the shift clock source over.
  spi_toggle_a: assert property (
    hit |=> st_q.spi != $past(st_q.spi))
    else $error("shift clock did not toggle on a match");

  // A period write lands in the period register.
  period_write_a: assert property (
    per_wr |=> st_q.period == $past(st_q.wdata))
    else $error("period write lost");

endmodule : pmt8_timer

// *** pmt8_timer_tb.sv ***
module pmt8_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

  // **********************************************
  // Signals and bookkeeping.
  // **********************************************
  logic mclk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata;
  logic awready, wready, bvalid, arready, rvalid, irq, pwm, spi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [33:0] exp_rv;
  logic [1:0] exp_bv;
  int mismatches = 0;
  int total_checks = 0;
  int pulse_cnt = 0;

  pmt8_timer i_dut (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .pwm_time_base(pwm), .spi_shift_clk(spi)
  );

  // The clock toggles every half period of 2 ns.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // **********************************************
  // Bus tasks; each starts and ends just after a rising edge.
  // **********************************************
  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] resp);
    logic ta, tw, aw, w, hit;
    aw = 1'b0;
    w = 1'b0;
    hit = 1'b0;
    exp_b.push_back(resp);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge mclk);
      if (ta) begin
        awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    while (!hit) begin
      @(negedge mclk);
      hit = bvalid;
      @(posedge mclk);
    end
  endtask : wr

  task automatic rd(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] resp);
    logic hit;
    hit = 1'b0;
    exp_r.push_back({resp, 24'h000000, d});
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit) begin
      @(negedge mclk);
      hit = arready;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge mclk);
      hit = rvalid;
      @(posedge mclk);
    end
  endtask : rd

  // Measures mclk cycles between two match pulses and the shift clock after each.
  task automatic interval(output int n, output logic s1, output logic s2);
    n = 0;
    do @(negedge mclk); while (pwm !== 1'b1);
    repeat (2) @(negedge mclk);
    s1 = spi;
    n = 2;
    do begin
      @(negedge mclk);
      n++;
    end while (pwm !== 1'b1);
    repeat (2) @(negedge mclk);
    s2 = spi;
    @(posedge mclk);
  endtask : interval

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Takes the oldest note whenever a bus answer appears, and counts match pulses.
  always @(negedge mclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_r.size() > 0) begin
      exp_rv = exp_r.pop_front();
      `CHK("read", exp_rv, {rresp, rdata})
    end
    if (bvalid === 1'b1 && bready === 1'b1 && exp_b.size() > 0) begin
      exp_bv = exp_b.pop_front();
      `CHK("bresp", exp_bv, bresp)
    end
    if (pwm === 1'b1) begin
      pulse_cnt++;
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  // **********************************************
  // Main sequence.
  // **********************************************
  initial begin
    int n, div;
    logic s1, s2;
    logic [31:0] r;
    logic [7:0] p;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    rst = 1'b1;
    void'($urandom(83802));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset values and an unmapped place.
    rd(pmt8_pkg::CTRL_IDX, 8'h00, 2'h0);
    rd(pmt8_pkg::PERIOD_IDX, 8'hFF, 2'h0);
    rd(pmt8_pkg::COUNT_IDX, 8'h00, 2'h0);
    rd(pmt8_pkg::FLAGS_IDX, 8'h00, 2'h0);
    rd(pmt8_pkg::ENABLES_IDX, 8'h00, 2'h0);
    rd(14'h0001, 8'h00, 2'h2);
    wr(14'h0001, 8'h55, 2'h2);
    // Random values written and read back while stopped.
    repeat (4) begin
      r = $urandom();
      wr(pmt8_pkg::COUNT_IDX, r[7:0], 2'h0);
      wr(pmt8_pkg::PERIOD_IDX, r[15:8], 2'h0);
      rd(pmt8_pkg::COUNT_IDX, r[7:0], 2'h0);
      rd(pmt8_pkg::PERIOD_IDX, r[15:8], 2'h0);
    end
    // Match spacing for every prescale code, with the shift clock toggling.
    for (int c = 0; c < 4; c++) begin
      p = 8'($urandom() % 8);
      div = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
      wr(pmt8_pkg::CTRL_IDX, 8'h00, 2'h0);
      wr(pmt8_pkg::COUNT_IDX, 8'h00, 2'h0);
      wr(pmt8_pkg::PERIOD_IDX, p, 2'h0);
      wr(pmt8_pkg::CTRL_IDX, {5'h01, 1'b0, 2'(c)} | 8'h04, 2'h0);
      interval(n, s1, s2);
      `CHK("spacing", 4 * div * (int'(p) + 1), n)
      `CHK("shift_clk", ~s1, s2)
    end
    // Postscale ratios: the flag rises on the (N+1)th match after a control write.
    for (int k = 0; k < 16; k++) begin
      wr(pmt8_pkg::CTRL_IDX, 8'h00, 2'h0);
      wr(pmt8_pkg::FLAGS_IDX, 8'h02, 2'h0);
      wr(pmt8_pkg::ENABLES_IDX, 8'h02, 2'h0);
      wr(pmt8_pkg::COUNT_IDX, 8'h00, 2'h0);
      wr(pmt8_pkg::PERIOD_IDX, 8'h00, 2'h0);
      pulse_cnt = 0;
      wr(pmt8_pkg::CTRL_IDX, {1'b0, 4'(k), 3'h4}, 2'h0);
      do @(negedge mclk); while (irq !== 1'b1);
      @(posedge mclk);
      `CHK("matches", k + 1, pulse_cnt)
    end
    rd(pmt8_pkg::FLAGS_IDX, 8'h02, 2'h0);
    wr(pmt8_pkg::ENABLES_IDX, 8'h00, 2'h0);
    @(negedge mclk);
    `CHK("irq_masked", 1'b0, irq)
    @(posedge mclk);
    wr(pmt8_pkg::CTRL_IDX, 8'h00, 2'h0);
    wr(pmt8_pkg::FLAGS_IDX, 8'h02, 2'h0);
    rd(pmt8_pkg::FLAGS_IDX, 8'h00, 2'h0);
    // A stopped timer holds its count; bit 7 of control never sticks.
    wr(pmt8_pkg::COUNT_IDX, 8'h5A, 2'h0);
    wr(pmt8_pkg::CTRL_IDX, 8'hFB, 2'h0);
    pulse_cnt = 0;
    repeat (200) @(posedge mclk);
    rd(pmt8_pkg::COUNT_IDX, 8'h5A, 2'h0);
    rd(pmt8_pkg::CTRL_IDX, 8'h7B, 2'h0);
    rd(pmt8_pkg::FLAGS_IDX, 8'h00, 2'h0);
    `CHK("pulses_off", 0, pulse_cnt)
    // A reset in mid-run brings back the reset values and leaves the timer stopped.
    wr(pmt8_pkg::PERIOD_IDX, 8'h33, 2'h0);
    wr(pmt8_pkg::CTRL_IDX, 8'h04, 2'h0);
    repeat (40) @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(pmt8_pkg::PERIOD_IDX, 8'hFF, 2'h0);
    rd(pmt8_pkg::COUNT_IDX, 8'h00, 2'h0);
    rd(pmt8_pkg::CTRL_IDX, 8'h00, 2'h0);
    print_verdict();
  end

endmodule : pmt8_timer_tb
